// ### rtl/afl_pkg.sv
// Purpose: Shared constants for the amplifier fault latch and gain select
// Assumes: Single 125 MHz clock, synchronous active-low reset
// Notes:   Gain codes map pin pair to preamp and overall gain in dB
package afl_pkg;
  localparam int unsigned CLK_DIV       = 2;
  localparam int unsigned SYNC_STAGES   = 2;
  localparam logic [1:0]  GAIN_CODE_0DB = 2'h0;
  localparam logic [1:0]  GAIN_CODE_6DB = 2'h1;
  localparam logic [1:0]  GAIN_CODE_12DB = 2'h2;
  localparam logic [1:0]  GAIN_CODE_18DB = 2'h3;
  localparam logic [5:0]  PRE_GAIN_0    = 6'h00;
  localparam logic [5:0]  PRE_GAIN_6    = 6'h06;
  localparam logic [5:0]  PRE_GAIN_12   = 6'h0C;
  localparam logic [5:0]  PRE_GAIN_18   = 6'h12;
  localparam logic [5:0]  AMP_GAIN_17   = 6'h11;
  localparam logic [5:0]  AMP_GAIN_23   = 6'h17;
  localparam logic [5:0]  AMP_GAIN_29   = 6'h1D;
  localparam logic [5:0]  AMP_GAIN_35   = 6'h23;
  // Status and mask bit positions
  localparam int unsigned ST_WARN       = 0;
  localparam int unsigned ST_THERM      = 1;
  localparam int unsigned ST_OVERCUR    = 2;
  localparam int unsigned ST_CLEARED    = 3;
  localparam int unsigned ST_W          = 4;
  localparam logic [1:0]  ADDR_STATUS   = 2'h0;
  localparam logic [1:0]  ADDR_MASK     = 2'h1;
  localparam logic [1:0]  ADDR_STATE    = 2'h2;
  localparam logic [3:0]  MASK_RESET    = 4'hF;
endpackage : afl_pkg

// ### rtl/afl_sync_if.sv
// Purpose: Carries synchronised control pins between modules
// Assumes: Same clock domain on both sides
// Notes:   Edge pulses are one cycle long
`timescale 1ns/1ps
interface afl_sync_if;
  logic       mute_n;
  logic       mute_fall;
  logic       mute_rise;
  logic [1:0] gain_code;
  modport src (output mute_n, output mute_fall, output mute_rise,
               output gain_code);
  modport dst (input mute_n, input mute_fall, input mute_rise,
               input gain_code);
endinterface : afl_sync_if

// ### rtl/afl_pin_sync.sv
// Purpose: Two-stage synchronisers for mute and gain pins, mute edges
// Assumes: Pins are asynchronous to clk
// Notes:   Edge detect only looks at the second stage onward
`timescale 1ns/1ps
module afl_pin_sync (
  input  wire logic   clk,
  input  wire logic   rstn,
  input  wire logic   mute_n_pin,
  input  wire logic   gain_sel_lsb,
  input  wire logic   gain_sel_msb,
  afl_sync_if.src     sync
);
  logic [2:0] meta;
  logic [2:0] stable;
  logic       mute_prev;

  always_ff @(posedge clk) begin
    if (!rstn) begin
      // Mute idles high so reset shows no false edge
      meta   <= 3'h4;
      stable <= 3'h4;
    end else begin
      meta   <= {mute_n_pin, gain_sel_msb, gain_sel_lsb};
      stable <= meta;
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      mute_prev <= 1'b1;
    end else begin
      mute_prev <= stable[2];
    end
  end

  assign sync.mute_n    = stable[2];
  assign sync.gain_code = stable[1:0];
  assign sync.mute_fall = mute_prev & ~stable[2];
  assign sync.mute_rise = ~mute_prev & stable[2];

  chk_edge_fall_src : assert property (@(posedge clk) disable iff (!rstn)
    sync.mute_fall |-> $past(stable[2]) && !stable[2])
    else $error("mute fall pulse without a falling edge");
endmodule : afl_pin_sync

// ### rtl/afl_clk_div.sv
// Purpose: Divide-by-two enable for the modulator clock
// Assumes: ext clock rate sampled as enable from clk
// Notes:   Produces one-cycle enable on every second ext clock rising edge
`timescale 1ns/1ps
module afl_clk_div (
  input  wire logic   clk,
  input  wire logic   rstn,
  input  wire logic   ext_clock_in,
  output logic        mod_clk_en,
  output logic        mod_clk
);
  logic [1:0] xs;
  logic       xprev;
  logic       rise;

  always_ff @(posedge clk) begin
    if (!rstn) begin
      xs    <= 2'h0;
      xprev <= 1'b0;
    end else begin
      xs    <= {xs[0], ext_clock_in};
      xprev <= xs[1];
    end
  end

  assign rise = xs[1] & ~xprev;

  always_ff @(posedge clk) begin
    if (!rstn) begin
      mod_clk    <= 1'b0;
      mod_clk_en <= 1'b0;
    end else begin
      mod_clk_en <= 1'b0;
      if (rise) begin
        mod_clk    <= ~mod_clk;
        mod_clk_en <= ~mod_clk;
      end
    end
  end

  chk_div_two : assert property (@(posedge clk) disable iff (!rstn)
    mod_clk_en |-> $past(rise) && !$past(mod_clk) && mod_clk)
    else $error("modulator enable not on every second input edge");
endmodule : afl_clk_div

// ### rtl/afl_top.sv
// Purpose: Fault latch, gain decode and power stage gating of amplifier
// Assumes: Fault detectors are level inputs from analog sensors
// Notes:   Flags are open-drain; oe high means pin pulled low
//
// Operation
// - The modulator clock is the external clock input divided by two.
// - Each channel gives a one-bit two-level stream to its power stage.
// - Gain pins decode to 0/6/12/18 dB preamp, 17/23/29/35 dB overall.
// - A temperature warning pulls the warning flag low.
// - A warning alone never stops the power stage.
// - Junction over 150 C pulls the error flag low.
// - The error flag stays latched until mute goes low then high.
// - Peak current at the limit latches the error flag.
// - Load short, short to supply and short to ground all set the error.
// - Both flags only ever pull low, never drive high.
// - Mute is active low; high lets the power stage run.
//
// The plain strobed port and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
module afl_top (
  input  wire logic        clk,
  input  wire logic        rstn,
  input  wire logic        ext_clock_in,
  input  wire logic        mute_n,
  input  wire logic        gain_sel_lsb,
  input  wire logic        gain_sel_msb,
  input  wire logic        temp_warn_det,
  input  wire logic        temp_shut_det,
  input  wire logic        short_load_det,
  input  wire logic        short_supply_det,
  input  wire logic        short_ground_det,
  input  wire logic [1:0]  pdm_in,
  input  wire logic [1:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [31:0] reg_rdata,
  output logic             irq,
  output logic             overtemp_warning_n_o,
  output logic             overtemp_warning_n_oe,
  output logic             error_n_o,
  output logic             error_n_oe,
  output logic             mod_clk,
  output logic             mod_clk_en,
  output logic      [1:0]  stage_out,
  output logic             stage_enable,
  output logic      [5:0]  pre_gain_db,
  output logic      [5:0]  amp_gain_db
);
  // ****************************************
  // Synchronisers
  // ****************************************
  afl_sync_if sync ();

  logic [4:0] det_meta;
  logic [4:0] det_s;
  logic       warn_s;
  logic       therm_s;
  logic       ocur_s;

  afl_pin_sync u_sync (
    .clk          (clk),
    .rstn         (rstn),
    .mute_n_pin   (mute_n),
    .gain_sel_lsb (gain_sel_lsb),
    .gain_sel_msb (gain_sel_msb),
    .sync         (sync)
  );

  afl_clk_div u_div (
    .clk          (clk),
    .rstn         (rstn),
    .ext_clock_in (ext_clock_in),
    .mod_clk_en   (mod_clk_en),
    .mod_clk      (mod_clk)
  );

  always_ff @(posedge clk) begin
    if (!rstn) begin
      det_meta <= 5'h00;
      det_s    <= 5'h00;
    end else begin
      det_meta <= {short_ground_det, short_supply_det, short_load_det,
                   temp_shut_det, temp_warn_det};
      det_s    <= det_meta;
    end
  end

  assign warn_s  = det_s[0];
  assign therm_s = det_s[1];
  assign ocur_s  = |det_s[4:2];

  // ****************************************
  // Gain decode
  // ****************************************
  function automatic logic [11:0] gain_lookup(input logic [1:0] code);
    case (code)
      afl_pkg::GAIN_CODE_0DB:
        gain_lookup = {afl_pkg::PRE_GAIN_0, afl_pkg::AMP_GAIN_17};
      afl_pkg::GAIN_CODE_6DB:
        gain_lookup = {afl_pkg::PRE_GAIN_6, afl_pkg::AMP_GAIN_23};
      afl_pkg::GAIN_CODE_12DB:
        gain_lookup = {afl_pkg::PRE_GAIN_12, afl_pkg::AMP_GAIN_29};
      default:
        gain_lookup = {afl_pkg::PRE_GAIN_18, afl_pkg::AMP_GAIN_35};
    endcase
  endfunction : gain_lookup

  always_ff @(posedge clk) begin
    if (!rstn) begin
      pre_gain_db <= afl_pkg::PRE_GAIN_0;
      amp_gain_db <= afl_pkg::AMP_GAIN_17;
    end else begin
      {pre_gain_db, amp_gain_db} <= gain_lookup(sync.gain_code);
    end
  end

  // ****************************************
  // Fault latch
  // ****************************************
  typedef enum logic [1:0] {FL_RUN, FL_LATCHED, FL_MUTE_LOW} afl_fault_e;
  afl_fault_e state;
  logic       err_latched;
  logic       clear_done;

  always_ff @(posedge clk) begin
    if (!rstn) begin
      state <= FL_RUN;
    end else begin
      case (state)
        FL_RUN:
          if (therm_s || ocur_s) state <= FL_LATCHED;
        FL_LATCHED:
          if (sync.mute_fall) state <= FL_MUTE_LOW;
        FL_MUTE_LOW:
          if (sync.mute_rise) begin
            if (therm_s || ocur_s) state <= FL_LATCHED;
            else state <= FL_RUN;
          end
        default: state <= FL_RUN;
      endcase
    end
  end

  assign err_latched = (state != FL_RUN);
  assign clear_done  = (state == FL_MUTE_LOW) && sync.mute_rise &&
                       !(therm_s || ocur_s);

  // ****************************************
  // Flags and power stage
  // ****************************************
  always_ff @(posedge clk) begin
    if (!rstn) begin
      overtemp_warning_n_oe <= 1'b0;
      error_n_oe            <= 1'b0;
    end else begin
      overtemp_warning_n_oe <= warn_s;
      error_n_oe            <= err_latched;
    end
  end

  assign overtemp_warning_n_o = 1'b0;
  assign error_n_o            = 1'b0;

  always_ff @(posedge clk) begin
    if (!rstn) begin
      stage_enable <= 1'b0;
      stage_out    <= 2'h0;
    end else begin
      // Warning has no say here
      stage_enable <= sync.mute_n && !err_latched;
      if (sync.mute_n && !err_latched && mod_clk_en) begin
        stage_out <= pdm_in;
      end else if (!(sync.mute_n && !err_latched)) begin
        stage_out <= 2'h0;
      end
    end
  end

  // ****************************************
  // Status, mask and interrupt
  // ****************************************
  logic [afl_pkg::ST_W-1:0] status;
  logic [afl_pkg::ST_W-1:0] mask;
  logic [afl_pkg::ST_W-1:0] events;
  logic [afl_pkg::ST_W-1:0] wclr;

  assign events = {clear_done, ocur_s, therm_s, warn_s};
  assign wclr   = (reg_wr && reg_addr == afl_pkg::ADDR_STATUS) ?
                  reg_wdata[afl_pkg::ST_W-1:0] : '0;

  always_ff @(posedge clk) begin
    if (!rstn) begin
      status <= '0;
    end else begin
      status <= (status & ~wclr) | events;
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      mask <= afl_pkg::MASK_RESET;
    end else if (reg_wr && reg_addr == afl_pkg::ADDR_MASK) begin
      mask <= reg_wdata[afl_pkg::ST_W-1:0];
    end
  end

  assign irq = |(status & ~mask);

  always_ff @(posedge clk) begin
    if (!rstn) begin
      reg_rdata <= 32'h0000_0000;
    end else if (reg_rd) begin
      case (reg_addr)
        afl_pkg::ADDR_STATUS: reg_rdata <= {28'h000_0000, status};
        afl_pkg::ADDR_MASK:   reg_rdata <= {28'h000_0000, mask};
        afl_pkg::ADDR_STATE:
          reg_rdata <= {16'h0000, 2'h0, amp_gain_db, 3'h0, err_latched,
                        sync.mute_n, stage_enable, sync.gain_code};
        default:              reg_rdata <= 32'h0000_0000;
      endcase
    end else begin
      reg_rdata <= 32'h0000_0000;
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  sequence s_mute_cycle;
    sync.mute_fall ##[1:1000] sync.mute_rise;
  endsequence

  chk_err_stays_latched : assert property (@(posedge clk) disable iff (!rstn)
    err_latched && !sync.mute_rise |=> err_latched)
    else $error("error latch dropped without mute rise");

  chk_err_sets : assert property (@(posedge clk) disable iff (!rstn)
    (therm_s || ocur_s) |=> err_latched)
    else $error("fault did not latch error");

  chk_err_pin : assert property (@(posedge clk) disable iff (!rstn)
    err_latched |=> error_n_oe)
    else $error("error pin not pulled low while latched");

  chk_warn_pin : assert property (@(posedge clk) disable iff (!rstn)
    warn_s |=> overtemp_warning_n_oe)
    else $error("warning pin not pulled low");

  chk_warn_runs : assert property (@(posedge clk) disable iff (!rstn)
    (sync.mute_n && !err_latched) |=> stage_enable)
    else $error("power stage stopped without fault");

  chk_stage_off : assert property (@(posedge clk) disable iff (!rstn)
    $past(err_latched) |-> !stage_enable)
    else $error("power stage on while error latched");

  chk_mute_off : assert property (@(posedge clk) disable iff (!rstn)
    !sync.mute_n |=> !stage_enable && stage_out == 2'h0)
    else $error("power stage on while muted");

  chk_open_drain : assert property (@(posedge clk) disable iff (!rstn)
    !error_n_o && !overtemp_warning_n_o)
    else $error("flag driven high");

  chk_gain_map : assert property (@(posedge clk) disable iff (!rstn)
    sync.gain_code == 2'h3 |=> amp_gain_db == afl_pkg::AMP_GAIN_35)
    else $error("gain code 3 not decoded");

  chk_clear_seq : assert property (@(posedge clk) disable iff (!rstn)
    err_latched ##0 s_mute_cycle ##0 !(therm_s || ocur_s)
    |=> !err_latched)
    else $error("clear sequence did not release error");

  sequence s_fault_now;
    therm_s || ocur_s;
  endsequence

  sequence s_clean_rise;
    sync.mute_rise ##0 !(therm_s || ocur_s);
  endsequence

  chk_fault_entry : assert property (@(posedge clk) disable iff (!rstn)
    state == FL_RUN ##0 s_fault_now |=> state == FL_LATCHED)
    else $error("fault did not enter the latch");

  chk_arm_clear : assert property (@(posedge clk) disable iff (!rstn)
    state == FL_LATCHED ##0 sync.mute_fall |=> state == FL_MUTE_LOW)
    else $error("mute fall did not arm the clear");

  chk_rise_refused : assert property (@(posedge clk) disable iff (!rstn)
    state == FL_LATCHED ##0 sync.mute_rise |=> state == FL_LATCHED)
    else $error("mute rise without fall left the latch");

  chk_relatch : assert property (@(posedge clk) disable iff (!rstn)
    state == FL_MUTE_LOW ##0 sync.mute_rise ##0 s_fault_now
    |=> state == FL_LATCHED)
    else $error("fault at mute rise did not relatch");

  chk_run_again : assert property (@(posedge clk) disable iff (!rstn)
    state == FL_MUTE_LOW ##0 s_clean_rise |=> state == FL_RUN)
    else $error("clean mute rise did not resume");

  chk_stage_load : assert property (@(posedge clk) disable iff (!rstn)
    sync.mute_n && !err_latched && mod_clk_en
    |=> stage_out == $past(pdm_in))
    else $error("stream bit not passed to power stage");

  chk_pre_gain : assert property (@(posedge clk) disable iff (!rstn)
    sync.gain_code == 2'h1 |=> pre_gain_db == afl_pkg::PRE_GAIN_6)
    else $error("gain code 1 not decoded");

  chk_gain_zero : assert property (@(posedge clk) disable iff (!rstn)
    sync.gain_code == 2'h0 |=> amp_gain_db == afl_pkg::AMP_GAIN_17)
    else $error("gain code 0 not decoded");

  chk_warn_release : assert property (@(posedge clk) disable iff (!rstn)
    !warn_s |=> !overtemp_warning_n_oe)
    else $error("warning pin held low without warning");

  chk_err_release : assert property (@(posedge clk) disable iff (!rstn)
    !err_latched |=> !error_n_oe)
    else $error("error pin held low after clear");

  // ****************************************
  // Register checks
  // ****************************************
  chk_rdata_idle : assert property (@(posedge clk) disable iff (!rstn)
    !reg_rd |=> reg_rdata == 32'h0000_0000)
    else $error("read data not zero outside a read");

  chk_rdata_status : assert property (@(posedge clk) disable iff (!rstn)
    reg_rd && reg_addr == afl_pkg::ADDR_STATUS |=>
    reg_rdata == {28'h000_0000, $past(status)})
    else $error("status read returned wrong bits");

  chk_mask_write : assert property (@(posedge clk) disable iff (!rstn)
    reg_wr && reg_addr == afl_pkg::ADDR_MASK |=>
    mask == $past(reg_wdata[afl_pkg::ST_W-1:0]))
    else $error("mask write did not land");

  chk_w1c_clear : assert property (@(posedge clk) disable iff (!rstn)
    reg_wr && reg_addr == afl_pkg::ADDR_STATUS && events == 4'h0 |=>
    (status & $past(reg_wdata[afl_pkg::ST_W-1:0])) == 4'h0)
    else $error("write of one did not clear status");

  chk_set_wins : assert property (@(posedge clk) disable iff (!rstn)
    (|events) |=> (status & $past(events)) == $past(events))
    else $error("status event lost");

  chk_clear_flag : assert property (@(posedge clk) disable iff (!rstn)
    clear_done |=> status[afl_pkg::ST_CLEARED])
    else $error("clear event not recorded");
endmodule : afl_top

// ### tb/afl_host_model.sv
// Purpose: Host model driving mute and gain pins, watching both flags
// Assumes: Flag lines are resolved with pull-ups in the bench
// Notes:   Pins change by non-blocking assignment after a rising edge
`timescale 1ns/1ps
module afl_host_model (
  input  wire logic clk,
  input  wire logic err_line,
  input  wire logic warn_line,
  output logic      mute_n,
  output logic      gain_sel_lsb,
  output logic      gain_sel_msb
);
  int fault_seen;
  int warn_seen;
  initial begin
    mute_n       = 1'b1;
    gain_sel_lsb = 1'b0;
    gain_sel_msb = 1'b0;
    fault_seen   = 0;
    warn_seen    = 0;
  end
  // Low on a line means some amplifier pulls it
  always @(posedge clk) begin
    if (err_line === 1'b0) fault_seen <= fault_seen + 1;
    if (warn_line === 1'b0) warn_seen <= warn_seen + 1;
  end
  task automatic set_mute(input logic v);
    @(posedge clk);
    mute_n <= v;
  endtask : set_mute
  task automatic set_gain(input logic [1:0] code);
    @(posedge clk);
    gain_sel_msb <= code[1];
    gain_sel_lsb <= code[0];
  endtask : set_gain
endmodule : afl_host_model

// ### tb/tb_top.sv
// Purpose: Self-checking bench for fault latch, gain and stage gating
// Assumes: Single 125 MHz clock, flags pulled up on the board
// Notes:   Expectations come from a small integer model
`timescale 1ns/1ps
module tb_top;
  logic        clk = 1'b0;
  logic        rstn = 1'b0;
  logic        ext_clock_in = 1'b0;
  logic        warn_det = 1'b0;
  logic [3:0]  flt = 4'h0;
  logic [1:0]  pdm_in = 2'h0;
  logic [1:0]  reg_addr = 2'h0;
  logic [31:0] reg_wdata = 32'h0000_0000;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic [31:0] reg_rdata, rd;
  logic        irq, w_o, w_oe, e_o, e_oe, mod_clk, mod_clk_en;
  logic [1:0]  stage_out;
  logic        stage_enable, mute_n, g_lsb, g_msb, err_line, warn_line;
  logic [5:0]  pre_gain_db, amp_gain_db;
  logic [31:0] rnd = 32'h0000_bfc6;
  logic        p_cond = 1'b0;
  logic [1:0]  p_v = 2'h0;
  logic        p_ext = 1'b0;
  logic        p_mod = 1'b0;
  int          bad_count = 0;
  int          n_compared = 0;
  int          ext_rises = 0;
  int          mod_rises = 0;
  int          dv = 0;
  int          model_status = 0;
  always #4 clk = ~clk;
  assign err_line  = e_oe ? e_o : 1'b1;
  assign warn_line = w_oe ? w_o : 1'b1;
  afl_host_model host (.clk(clk), .err_line(err_line),
    .warn_line(warn_line), .mute_n(mute_n), .gain_sel_lsb(g_lsb),
    .gain_sel_msb(g_msb));
  afl_top uut (.clk(clk), .rstn(rstn), .ext_clock_in(ext_clock_in),
    .mute_n(mute_n), .gain_sel_lsb(g_lsb), .gain_sel_msb(g_msb),
    .temp_warn_det(warn_det), .temp_shut_det(flt[0]),
    .short_load_det(flt[1]), .short_supply_det(flt[2]),
    .short_ground_det(flt[3]), .pdm_in(pdm_in), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .irq(irq), .overtemp_warning_n_o(w_o),
    .overtemp_warning_n_oe(w_oe), .error_n_o(e_o), .error_n_oe(e_oe),
    .mod_clk(mod_clk), .mod_clk_en(mod_clk_en), .stage_out(stage_out),
    .stage_enable(stage_enable), .pre_gain_db(pre_gain_db),
    .amp_gain_db(amp_gain_db));
  // ********************************
  // Shared tasks
  // ********************************
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      bad_count++;
      $display("wrong value t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic reg_write(input logic [1:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk);
    reg_wr    <= 1'b0;
  endtask : reg_write
  task automatic reg_read(input logic [1:0] a, output logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk);
    reg_rd   <= 1'b0;
    @(posedge clk);
    d = reg_rdata;
  endtask : reg_read
  task automatic tally_and_finish;
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : tally_and_finish
  function automatic logic [31:0] xorshift(input logic [31:0] x);
    x = x ^ (x << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction : xorshift
  // ********************************
  // Stimulus and monitors
  // ********************************
  always @(posedge clk) begin
    rnd    <= xorshift(rnd);
    pdm_in <= rnd[1:0];
    dv     <= (dv == 2) ? 0 : dv + 1;
    if (dv == 2) ext_clock_in <= ~ext_clock_in;
    p_cond <= mod_clk_en & stage_enable;
    p_v    <= pdm_in;
    p_ext  <= ext_clock_in;
    p_mod  <= mod_clk;
    if (rstn && ext_clock_in && !p_ext) ext_rises <= ext_rises + 1;
    if (rstn && mod_clk && !p_mod) mod_rises <= mod_rises + 1;
    if (rstn && p_cond && stage_enable) check(stage_out, p_v);
  end
  initial begin
    #400000;
    bad_count++;
    tally_and_finish();
  end
  initial begin
    repeat (16) @(posedge clk);
    rstn <= 1'b1;
    repeat (4) @(posedge clk);
    check(amp_gain_db, 32'h0000_0011);
    reg_read(afl_pkg::ADDR_MASK, rd);
    check(rd, 32'h0000_000F);
    reg_write(2'h3, 32'h0000_0000);
    reg_read(2'h3, rd);
    check(rd, 32'h0000_0000);
    reg_read(afl_pkg::ADDR_MASK, rd);
    check(rd, 32'h0000_000F);
    for (int i = 0; i < 4; i++) begin
      host.set_gain(i[1:0]);
      repeat (6) @(posedge clk);
      check(pre_gain_db, 6 * i);
      check(amp_gain_db, 17 + 6 * i);
      reg_read(afl_pkg::ADDR_STATE, rd);
      check(rd[1:0], i);
    end
    warn_det <= 1'b1;
    repeat (8) @(posedge clk);
    check(warn_line, 1'b0);
    check(w_o, 1'b0);
    check(stage_enable, 1'b1);
    check(irq, 1'b0);
    warn_det <= 1'b0;
    model_status = 1 << afl_pkg::ST_WARN;
    reg_read(afl_pkg::ADDR_STATUS, rd);
    check(rd, model_status);
    reg_write(afl_pkg::ADDR_STATUS, 32'h0000_000F);
    check(warn_line, 1'b1);
    reg_write(afl_pkg::ADDR_MASK, 32'h0000_0000);
    for (int k = 0; k < 4; k++) begin
      flt[k] <= 1'b1;
      repeat (3) @(posedge clk);
      flt[k] <= 1'b0;
      repeat (8) @(posedge clk);
      check(err_line, 1'b0);
      check(e_o, 1'b0);
      check(stage_enable, 1'b0);
      check(stage_out, 2'h0);
      check(irq, 1'b1);
      host.set_mute(1'b1);
      repeat (20) @(posedge clk);
      check(err_line, 1'b0);
      check(stage_enable, 1'b0);
      if (host.fault_seen > 0) host.set_mute(1'b0);
      repeat (6) @(posedge clk);
      check(stage_enable, 1'b0);
      host.set_mute(1'b1);
      repeat (8) @(posedge clk);
      check(err_line, 1'b1);
      check(stage_enable, 1'b1);
      model_status = (1 << afl_pkg::ST_CLEARED) |
        (1 << ((k == 0) ? afl_pkg::ST_THERM : afl_pkg::ST_OVERCUR));
      reg_read(afl_pkg::ADDR_STATUS, rd);
      check(rd, model_status);
      reg_write(afl_pkg::ADDR_STATUS, 32'h0000_000F);
      repeat (2) @(posedge clk);
      check(irq, 1'b0);
    end
    // Mute alone, then a fault that outlives one clear attempt
    host.set_mute(1'b0);
    repeat (6) @(posedge clk);
    check(stage_enable, 1'b0);
    check(stage_out, 2'h0);
    check(err_line, 1'b1);
    flt[0] <= 1'b1;
    repeat (6) @(posedge clk);
    host.set_mute(1'b1);
    repeat (6) @(posedge clk);
    host.set_mute(1'b0);
    repeat (6) @(posedge clk);
    host.set_mute(1'b1);
    repeat (8) @(posedge clk);
    check(err_line, 1'b0);
    check(stage_enable, 1'b0);
    flt[0] <= 1'b0;
    host.set_mute(1'b0);
    repeat (6) @(posedge clk);
    host.set_mute(1'b1);
    repeat (8) @(posedge clk);
    check(err_line, 1'b1);
    check(stage_enable, 1'b1);
    check((mod_rises * 2 + 2 >= ext_rises) &&
          (mod_rises * 2 <= ext_rises + 2), 1'b1);
    tally_and_finish();
  end
endmodule : tb_top
